/* qxip_pkg.sv */
package qxip_pkg;
  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CONFIG = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MEM_ADDR = 8'h0C;
  localparam logic [7:0] OFS_MEM_DATA = 8'h10;
  localparam logic [7:0] OFS_READ_ADDR = 8'h14;
  localparam int CTRL_QE_BIT = 0;
  localparam int CTRL_QCM_BIT = 1;
  localparam int CTRL_BUSY_BIT = 2;
  localparam int CFG_DC_LOW_BIT = 6;
  localparam int CFG_DC_HIGH_BIT = 7;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [1:0] DC_RESET = 2'h0;
  // ----------------------------------------------------------------
  // Opcodes, wrap codes and phase lengths
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_QUAD_OUT_READ = 8'h6B;
  localparam logic [7:0] OP_QUAD_IO_READ = 8'hEB;
  localparam logic [7:0] OP_QUAD_IO_SHORT = 8'hE7;
  localparam logic [7:0] OP_SET_BURST = 8'hC0;
  localparam logic [3:0] WRAP_OFF_NIBBLE = 4'h1;
  localparam logic [4:0] CMD_CLKS_SINGLE = 5'h08;
  localparam logic [4:0] CMD_CLKS_QUAD = 5'h02;
  localparam logic [4:0] ADDR_CLKS_SINGLE = 5'h18;
  localparam logic [4:0] ADDR_CLKS_QUAD = 5'h06;
  localparam logic [4:0] DUMMY_QUAD_OUT = 5'h08;
  localparam logic [4:0] DUMMY_SHORT = 5'h04;
  localparam logic [4:0] DUMMY_DC0 = 5'h06;
  localparam logic [4:0] DUMMY_DC1 = 5'h04;
  localparam logic [4:0] DUMMY_DC2 = 5'h08;
  localparam logic [4:0] DUMMY_DC3 = 5'h0A;
  localparam logic [4:0] IND_CLKS = 5'h02;
  localparam logic [3:0] FF_EXIT_CLKS = 4'h8;
  localparam int ADDR_W = 24;
  localparam int MEM_AW = 8;
  // ----------------------------------------------------------------
  // Engine states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_CMD = 3'b000,
    ST_ADDR = 3'b001,
    ST_DUMMY = 3'b010,
    ST_DATA = 3'b011,
    ST_BURST = 3'b100,
    ST_IGNORE = 3'b101
  } state_t;
endpackage : qxip_pkg

/* mem_port_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Write and read port of the byte store
interface mem_port_if #(parameter int AW = 8);
  logic wrEn;
  logic [AW-1:0] wrAddr;
  logic [7:0] wrData;
  logic [AW-1:0] rdAddr;
  logic [7:0] rdData;
  modport engine (output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
  modport store (input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface : mem_port_if
`default_nettype wire

/* pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic resetN,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] stage1_reg;
  // Two flip-flops per pin, first stage read only by the second
  always_ff @(posedge clk or negedge resetN) begin
    if (!resetN) begin
      stage1_reg <= '0;
      dout <= '0;
    end else begin
      stage1_reg <= din;
      dout <= stage1_reg;
    end
  end
endmodule : pin_sync
`default_nettype wire

/* byte_store.sv */
`timescale 1ns/1ps
`default_nettype none
module byte_store
  import qxip_pkg::*;
(
  input wire logic clk,
  input wire logic resetN,
  mem_port_if.store port
);
  logic [7:0] mem [0:(1<<MEM_AW)-1];
  // Array write, no reset on contents
  always_ff @(posedge clk) begin
    if (port.wrEn) begin
      mem[port.wrAddr] <= port.wrData;
    end
  end
  // Registered read data
  always_ff @(posedge clk or negedge resetN) begin
    if (!resetN) begin
      port.rdData <= 8'h00;
    end else begin
      port.rdData <= mem[port.rdAddr];
    end
  end
endmodule : byte_store
`default_nettype wire

/* quad_read_burst_xip_engine.sv */
// How it works
// - address on rising, data on falling edge
// - address steps per byte, rolls to zero
// - quad output read: serial address, 8 dummies
// - chip select high stops driving, ends read
// - reads ignored while busy cycle runs, except enhance-mode frames
// - quad I/O read: 4-line address, 6 dummies
// - quad I/O read accepted in quad mode
// - short-dummy read E7h uses 4 dummies
// - config bits 6,7 pick dummy count
// - wrapping off at reset, sticky until changed
// - codes 00h-03h give 8..64 bytes, 1xh off
// - wrap inside aligned block of chosen size
// - wrap applies to EBh and E7h reads
// - burst command takes 8 or 2 clocks
// - complementary indicator nibbles keep enhance mode
// - otherwise leave enhance after next select cycle
// - enhance mode starts frame at address
// - enhance only from EBh quad I/O read
//
// The placing of the registers and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module quad_read_burst_xip_engine
  import qxip_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic sclk,
  input wire logic chipSelectN,
  input wire logic [3:0] ioLineIn,
  output logic [3:0] ioLineOut,
  output logic [3:0] ioLineOe
);
  // ----------------------------------------------------------------
  // Pin synchronisers and serial clock edges
  // ----------------------------------------------------------------
  logic [5:0] pinsS;
  logic sclkS, csS, sclkD_reg, rise, fall;
  logic [3:0] ioS;
  // Select is synced inverted so that the reset value reads as deselected
  pin_sync #(.W(6)) u_sync (
    .clk(mclk), .resetN(reset_n), .din({sclk, ~chipSelectN, ioLineIn}), .dout(pinsS)
  );
  assign sclkS = pinsS[5];
  assign csS = ~pinsS[4]; // High while deselected
  assign ioS = pinsS[3:0];
  assign rise = sclkS & ~sclkD_reg & ~csS;
  assign fall = ~sclkS & sclkD_reg & ~csS;

  // ----------------------------------------------------------------
  // Bus-side registers
  // ----------------------------------------------------------------
  logic [2:0] ctrl_reg;
  logic [1:0] dcfg_reg;
  logic [MEM_AW-1:0] memAddr_reg;
  logic wrPend_reg;
  logic [7:0] wrOfs_reg;
  logic quadEn, quadCmdMode, busyCycle;
  logic apSel;
  logic [7:0] apOfs;
  logic [31:0] readMux;
  assign quadEn = ctrl_reg[CTRL_QE_BIT];
  assign quadCmdMode = ctrl_reg[CTRL_QCM_BIT];
  assign busyCycle = ctrl_reg[CTRL_BUSY_BIT];

  // ----------------------------------------------------------------
  // Engine state
  // ----------------------------------------------------------------
  state_t state_reg;
  logic [4:0] bitCnt_reg, dummyTarget_reg;
  logic [3:0] frameCnt_reg;
  logic [23:0] shift_reg, shiftNext;
  logic [ADDR_W-1:0] addr_reg, addrNext, wrapMask;
  logic quadAddr_reg, isEb_reg, wrapOk_reg, nibble_reg, ffRun_reg;
  logic enhance_reg, enhanceNext_reg, wrapEn_reg;
  logic [1:0] wrapSel_reg;
  logic [7:0] rxByte;
  logic [4:0] cmdClks, bitCntInc, dcDummy, idleDummy;
  logic [3:0] exitMask;
  logic phaseDone, isRead, readBlocked, ffExit, lineQuad, indComp;
  mem_port_if #(.AW(MEM_AW)) memPort ();
  byte_store u_store (.clk(mclk), .resetN(reset_n), .port(memPort.store));

  // Lane width and shift of the current phase
  assign lineQuad = (state_reg == ST_ADDR || state_reg == ST_DUMMY) ? quadAddr_reg : quadCmdMode;
  assign shiftNext = lineQuad ? {shift_reg[19:0], ioS} : {shift_reg[22:0], ioS[0]};
  assign rxByte = shiftNext[7:0];
  assign bitCntInc = bitCnt_reg + 5'h01;
  assign cmdClks = quadCmdMode ? CMD_CLKS_QUAD : CMD_CLKS_SINGLE;
  // Dummy count from the configuration bits
  assign dcDummy = (dcfg_reg == 2'h0) ? DUMMY_DC0 : (dcfg_reg == 2'h1) ? DUMMY_DC1 :
                   (dcfg_reg == 2'h2) ? DUMMY_DC2 : DUMMY_DC3;
  assign idleDummy = dcDummy;
  // Opcode decode and read gating
  assign isRead = (rxByte == OP_QUAD_IO_READ) ||
                  (!quadCmdMode && (rxByte == OP_QUAD_OUT_READ || rxByte == OP_QUAD_IO_SHORT));
  assign readBlocked = busyCycle || (!quadCmdMode && !quadEn);
  assign phaseDone = (state_reg == ST_CMD || state_reg == ST_BURST) ? (bitCntInc == cmdClks) :
                     (state_reg == ST_ADDR) ?
                     (bitCntInc == (quadAddr_reg ? ADDR_CLKS_QUAD : ADDR_CLKS_SINGLE)) :
                     (bitCntInc == dummyTarget_reg);
  // Forced exit: eight clocks with line 0 high (all four lines in quad command mode) at frame start in enhance mode
  assign exitMask = quadCmdMode ? 4'hF : 4'h1;
  assign ffExit = enhance_reg && ffRun_reg && ((ioS & exitMask) == exitMask) &&
                  (frameCnt_reg == FF_EXIT_CLKS - 4'h1);
  assign indComp = (rxByte[7:4] == ~rxByte[3:0]);
  // Next read address with optional wrap inside an aligned block
  assign wrapMask = (wrapEn_reg && wrapOk_reg) ?
                    ADDR_W'((24'h000008 << wrapSel_reg) - 24'h000001) : '1;
  assign addrNext = (addr_reg & ~wrapMask) | ((addr_reg + 24'h000001) & wrapMask);

  // ----------------------------------------------------------------
  // Serial engine
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sclkD_reg <= 1'b0;
      state_reg <= ST_CMD;
      bitCnt_reg <= 5'h00;
      frameCnt_reg <= 4'h0;
      shift_reg <= 24'h000000;
      addr_reg <= '0;
      dummyTarget_reg <= DUMMY_DC0;
      quadAddr_reg <= 1'b0;
      isEb_reg <= 1'b0;
      wrapOk_reg <= 1'b0;
      nibble_reg <= 1'b0;
      ffRun_reg <= 1'b1;
      enhance_reg <= 1'b0;
      enhanceNext_reg <= 1'b0;
      wrapEn_reg <= 1'b0;
      wrapSel_reg <= 2'h0;
      ioLineOut <= 4'h0;
      ioLineOe <= 4'h0;
    end else begin
      sclkD_reg <= sclkS;
      if (csS) begin
        // Frame over: release lines, apply pending enhance state
        ioLineOe <= 4'h0;
        enhance_reg <= enhanceNext_reg;
        state_reg <= enhanceNext_reg ? ST_ADDR : ST_CMD;
        quadAddr_reg <= enhanceNext_reg;
        isEb_reg <= enhanceNext_reg;
        wrapOk_reg <= enhanceNext_reg;
        dummyTarget_reg <= idleDummy;
        bitCnt_reg <= 5'h00;
        frameCnt_reg <= 4'h0;
        ffRun_reg <= 1'b1;
        nibble_reg <= 1'b0;
      end else if (rise) begin
        shift_reg <= shiftNext;
        bitCnt_reg <= phaseDone ? 5'h00 : bitCntInc;
        if (frameCnt_reg != 4'hF) begin
          frameCnt_reg <= frameCnt_reg + 4'h1;
        end
        ffRun_reg <= ffRun_reg && ((ioS & exitMask) == exitMask);
        if (ffExit) begin
          enhance_reg <= 1'b0;
          enhanceNext_reg <= 1'b0;
          state_reg <= ST_IGNORE;
        end else begin
          case (state_reg)
            ST_CMD: begin
              if (phaseDone) begin
                quadAddr_reg <= (rxByte != OP_QUAD_OUT_READ);
                isEb_reg <= (rxByte == OP_QUAD_IO_READ);
                wrapOk_reg <= (rxByte != OP_QUAD_OUT_READ);
                dummyTarget_reg <= (rxByte == OP_QUAD_OUT_READ) ? DUMMY_QUAD_OUT :
                                   (rxByte == OP_QUAD_IO_SHORT) ? DUMMY_SHORT : dcDummy;
                if (isRead && !readBlocked) begin
                  state_reg <= ST_ADDR;
                end else if (rxByte == OP_SET_BURST) begin
                  state_reg <= ST_BURST;
                end else begin
                  state_reg <= ST_IGNORE;
                end
              end
            end
            ST_ADDR: begin
              if (phaseDone) begin
                addr_reg <= shiftNext[ADDR_W-1:0];
                state_reg <= ST_DUMMY;
              end
            end
            ST_DUMMY: begin
              if (isEb_reg && bitCnt_reg == IND_CLKS - 5'h01) begin
                enhanceNext_reg <= indComp;
              end
              if (phaseDone) begin
                state_reg <= ST_DATA;
                nibble_reg <= 1'b0;
              end
            end
            ST_BURST: begin
              if (phaseDone) begin
                if (rxByte[7:2] == 6'h00) begin
                  wrapEn_reg <= 1'b1;
                  wrapSel_reg <= rxByte[1:0];
                end else if (rxByte[7:4] == WRAP_OFF_NIBBLE) begin
                  wrapEn_reg <= 1'b0;
                end
                state_reg <= ST_IGNORE;
              end
            end
            ST_DATA, ST_IGNORE: begin
              state_reg <= state_reg;
            end
            default: begin
              state_reg <= ST_IGNORE;
            end
          endcase
        end
      end else if (fall && state_reg == ST_DATA) begin
        // One nibble per falling edge, address steps after the low nibble
        ioLineOe <= 4'hF;
        ioLineOut <= nibble_reg ? memPort.rdData[3:0] : memPort.rdData[7:4];
        nibble_reg <= ~nibble_reg;
        if (nibble_reg) begin
          addr_reg <= addrNext;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------------------------------
  assign apSel = hsel && htrans[1] && hready;
  assign apOfs = haddr[7:0];
  assign readMux = (apOfs == OFS_CTRL) ? {29'h0, ctrl_reg} :
                   (apOfs == OFS_CONFIG) ? {24'h0, dcfg_reg, 6'h00} :
                   (apOfs == OFS_STATUS) ? {24'h0, 1'b0, state_reg, wrapSel_reg,
                                            wrapEn_reg, enhance_reg} :
                   (apOfs == OFS_MEM_ADDR) ? {24'h0, memAddr_reg} :
                   (apOfs == OFS_READ_ADDR) ? {8'h00, addr_reg} : 32'h0000_0000;
  assign memPort.wrEn = wrPend_reg && (wrOfs_reg == OFS_MEM_DATA);
  assign memPort.wrAddr = memAddr_reg;
  assign memPort.wrData = hwdata[7:0];
  assign memPort.rdAddr = addr_reg[MEM_AW-1:0];

  // Address phase capture and read data
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wrPend_reg <= 1'b0;
      wrOfs_reg <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wrPend_reg <= apSel && hwrite;
      wrOfs_reg <= apOfs;
      if (apSel && !hwrite) begin
        hrdata <= readMux;
      end
    end
  end

  // Register writes in the data phase
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= CTRL_RESET;
      dcfg_reg <= DC_RESET;
      memAddr_reg <= '0;
    end else if (wrPend_reg) begin
      if (wrOfs_reg == OFS_CTRL) begin
        ctrl_reg <= hwdata[2:0];
      end
      if (wrOfs_reg == OFS_CONFIG) begin
        dcfg_reg <= {hwdata[CFG_DC_HIGH_BIT], hwdata[CFG_DC_LOW_BIT]};
      end
      if (wrOfs_reg == OFS_MEM_ADDR) begin
        memAddr_reg <= hwdata[MEM_AW-1:0];
      end else if (wrOfs_reg == OFS_MEM_DATA) begin
        memAddr_reg <= memAddr_reg + MEM_AW'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  property p_release;
    csS |=> ioLineOe == 4'h0;
  endproperty
  a_release: assert property (p_release) else $error("lines driven with select high");
  property p_outFall;
    $changed(ioLineOut) |-> $past(fall) && $past(state_reg) == ST_DATA;
  endproperty
  a_outFall: assert property (p_outFall) else $error("data changed off falling edge");
  property p_step;
    fall && state_reg == ST_DATA && nibble_reg && !(wrapEn_reg && wrapOk_reg)
      |=> addr_reg == $past(addr_reg) + 24'h000001;
  endproperty
  a_step: assert property (p_step) else $error("address did not step by one");
  property p_wrapBlock;
    fall && state_reg == ST_DATA && nibble_reg && wrapEn_reg && wrapOk_reg
      |=> (addr_reg & ~wrapMask) == ($past(addr_reg) & ~wrapMask);
  endproperty
  a_wrapBlock: assert property (p_wrapBlock) else $error("wrap left aligned block");
  property p_wrapSet;
    $rose(wrapEn_reg) |-> $past(state_reg) == ST_BURST && $past(rxByte[7:2]) == 6'h00;
  endproperty
  a_wrapSet: assert property (p_wrapSet) else $error("wrap enabled without burst code");
  property p_busy;
    rise && state_reg == ST_CMD && phaseDone && isRead && busyCycle |=> state_reg == ST_IGNORE;
  endproperty
  a_busy: assert property (p_busy) else $error("read accepted while busy");
  property p_short;
    rise && state_reg == ST_CMD && phaseDone && !quadCmdMode && rxByte == OP_QUAD_IO_SHORT
      |=> dummyTarget_reg == 5'h04 && quadAddr_reg;
  endproperty
  a_short: assert property (p_short) else $error("short read dummy count wrong");
  property p_xipStart;
    $fell(csS) && enhance_reg |-> state_reg == ST_ADDR && bitCnt_reg == 5'h00;
  endproperty
  a_xipStart: assert property (p_xipStart) else $error("enhance frame not at address");
  property p_ebOnly;
    $rose(enhanceNext_reg) |-> $past(isEb_reg) && $past(state_reg) == ST_DUMMY;
  endproperty
  a_ebOnly: assert property (p_ebOnly) else $error("enhance entered from wrong read");
  c_data: cover property (state_reg == ST_DATA && fall ##[1:100] csS);
  c_xip: cover property ($rose(enhance_reg));
  c_wrap: cover property ($rose(wrapEn_reg));
  c_exit: cover property (ffExit);
endmodule : quad_read_burst_xip_engine
`default_nettype wire

/* flash_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Host flash controller driving the serial link
// ------------------------------------------------------------
module flash_host_model (
  input wire logic mclk,
  input wire logic [3:0] ioLineOut,
  output logic sclk,
  output logic chipSelectN,
  output logic [3:0] hostOut
);
  logic [7:0] rdByte [0:7];
  logic [3:0] lastNib;
  // Link idles with the clock low and select high
  initial begin
    sclk = 1'b0;
    chipSelectN = 1'b1;
    hostOut = 4'h0;
  end
  // One serial clock: lines change while low, sampled late in the high phase
  task automatic clk1(input logic [3:0] v);
    hostOut <= v;
    repeat (4) @(posedge mclk);
    sclk <= 1'b1;
    repeat (4) @(posedge mclk);
    lastNib = ioLineOut;
    sclk <= 1'b0;
  endtask : clk1
  // A byte on four lines or on line 0 with the spare lines toggling
  task automatic sendByte(input logic q, input logic [7:0] b);
    if (q) begin
      clk1(b[7:4]);
      clk1(b[3:0]);
    end else begin
      for (int i = 7; i >= 0; i--) clk1({~hostOut[3:1], b[i]});
    end
  endtask : sendByte
  // Read frame; select is left low so the caller decides when to end it
  task automatic readFrame(input logic qCmd, input logic hasCmd, input logic [7:0] op,
                           input logic qAddr, input logic [23:0] a, input logic [7:0] ind,
                           input int dummies, input int nBytes);
    chipSelectN <= 1'b0;
    repeat (4) @(posedge mclk);
    if (hasCmd) sendByte(qCmd, op);
    if (qAddr) for (int i = 5; i >= 0; i--) clk1(a[i*4 +: 4]);
    else for (int i = 2; i >= 0; i--) sendByte(1'b0, a[i*8 +: 8]);
    for (int i = 0; i < dummies; i++) clk1(i == 0 ? ind[7:4] : (i == 1 ? ind[3:0] : 4'h0));
    for (int k = 0; k < nBytes; k++) begin
      clk1(~hostOut);
      rdByte[k][7:4] = lastNib;
      clk1(~hostOut);
      rdByte[k][3:0] = lastNib;
    end
  endtask : readFrame
  // Raise select; released lines go to the inverse of their last level
  task automatic endFrame();
    chipSelectN <= 1'b1;
    hostOut <= ~hostOut;
    repeat (6) @(posedge mclk);
  endtask : endFrame
  // Burst length: opcode then wrap code, then select high
  task automatic setBurst(input logic q, input logic [7:0] code);
    chipSelectN <= 1'b0;
    repeat (4) @(posedge mclk);
    sendByte(q, 8'hC0);
    sendByte(q, code);
    endFrame();
  endtask : setBurst
  // Eight clocks with line 0 high (all four lines when q is set) at the start of a frame; select is left low
  task automatic exitFrame(input logic q);
    chipSelectN <= 1'b0;
    repeat (4) @(posedge mclk);
    for (int i = 0; i < 8; i++) clk1(q ? 4'hF : {~hostOut[3:1], 1'b1});
  endtask : exitFrame
endmodule : flash_host_model
`default_nettype wire

/* quad_read_burst_xip_engine_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define HM flash_host_model_i
`define CHECK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin fails++; $display("ERROR %s expected %0h seen %0h", what, exp, got); end end
module quad_read_burst_xip_engine_tb;
  import qxip_pkg::*;
  logic mclk, reset_n, hsel, hwrite, hreadyout, hresp, sclk, chipSelectN;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] ioLineIn, ioLineOut, ioLineOe, hostOut;
  int fails = 0;
  int samples_checked = 0;
  // Wire level of each line: engine output where its enable is set, host output elsewhere
  assign ioLineIn = (ioLineOe & ioLineOut) | (~ioLineOe & hostOut);
  quad_read_burst_xip_engine quad_read_burst_xip_engine_i (.mclk(mclk), .reset_n(reset_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .sclk(sclk), .chipSelectN(chipSelectN), .ioLineIn(ioLineIn),
    .ioLineOut(ioLineOut), .ioLineOe(ioLineOe));
  flash_host_model flash_host_model_i (.mclk(mclk), .ioLineOut(ioLineOut), .sclk(sclk),
    .chipSelectN(chipSelectN), .hostOut(hostOut));
  // ------------------------------------------------------------
  // Bus cycles and helpers
  // ------------------------------------------------------------
  always #50 mclk = ~mclk;
  function automatic logic [7:0] memVal(input logic [23:0] a);
    return a[7:0] ^ 8'h5A;
  endfunction : memVal
  task automatic ahbCycle(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask : ahbCycle
  task automatic ahbWrite(input logic [7:0] a, input logic [31:0] wd);
    ahbCycle(1'b1, a, wd);
  endtask : ahbWrite
  task automatic ahbRead(input logic [7:0] a);
    ahbCycle(1'b0, a, 32'h0);
  endtask : ahbRead
  task automatic chkBytes(input logic [23:0] a, input int n, input int dep);
    logic [23:0] ea;
    for (int k = 0; k < n; k++) begin
      ea = (dep == 0) ? a + 24'(k) : ((a & ~24'(dep - 1)) | ((a + 24'(k)) & 24'(dep - 1)));
      `CHECK("read byte", memVal(ea), `HM.rdByte[k])
    end
  endtask : chkBytes
  task automatic chkEnh(input logic exp);
    ahbRead(OFS_STATUS);
    `CHECK("enhance flag", exp, d[0])
  endtask : chkEnh
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic scnReset();
    ahbRead(OFS_STATUS);
    `CHECK("wrap and enhance after reset", 2'b00, d[1:0])
    `CHECK("ready after reset", 1'b1, hreadyout)
    ahbRead(8'h40);
    `CHECK("unmapped read", 32'h0, d)
    `CHECK("bus response", 1'b0, hresp)
    ahbWrite(OFS_MEM_ADDR, 32'h0);
    for (int i = 0; i < 256; i++) ahbWrite(OFS_MEM_DATA, {24'h0, memVal(24'(i))});
  endtask : scnReset
  task automatic scnRefused();
    ahbWrite(OFS_CTRL, 32'h0);
    `HM.readFrame(1'b0, 1'b1, OP_QUAD_IO_READ, 1'b1, 24'h10, 8'h00, 6, 1);
    `CHECK("lines without quad enable", 4'h0, ioLineOe)
    `HM.endFrame();
    ahbWrite(OFS_CTRL, 32'h5);
    `HM.readFrame(1'b0, 1'b1, OP_QUAD_OUT_READ, 1'b0, 24'h10, 8'h00, 8, 1);
    `CHECK("lines while busy", 4'h0, ioLineOe)
    `HM.endFrame();
    ahbRead(OFS_CTRL);
    `CHECK("busy cycle kept", 3'h5, d[2:0])
    ahbWrite(OFS_CTRL, 32'h1);
  endtask : scnRefused
  task automatic scnQuadOut();
    `HM.readFrame(1'b0, 1'b1, OP_QUAD_OUT_READ, 1'b0, 24'hFFFFFE, 8'h00, 8, 4);
    chkBytes(24'hFFFFFE, 4, 0);
    `CHECK("lines driven in data", 4'hF, ioLineOe)
    `HM.endFrame();
    `CHECK("lines released on abort", 4'h0, ioLineOe)
  endtask : scnQuadOut
  task automatic scnDummy();
    logic [4:0] dc [4];
    dc = '{DUMMY_DC0, DUMMY_DC1, DUMMY_DC2, DUMMY_DC3};
    for (int i = 0; i < 4; i++) begin
      ahbWrite(OFS_CONFIG, 32'(i) << 6);
      `HM.readFrame(1'b0, 1'b1, OP_QUAD_IO_READ, 1'b1, 24'h120 + 24'(i), 8'h00, int'(dc[i]), 2);
      chkBytes(24'h120 + 24'(i), 2, 0);
      `HM.endFrame();
    end
    ahbWrite(OFS_CONFIG, 32'h0);
    `HM.readFrame(1'b0, 1'b1, OP_QUAD_IO_SHORT, 1'b1, 24'hF0, 8'h00, int'(DUMMY_SHORT), 2);
    chkBytes(24'hF0, 2, 0);
    `HM.endFrame();
  endtask : scnDummy
  task automatic scnBurst();
    int dep;
    logic [23:0] st;
    for (int i = 0; i < 4; i++) begin
      dep = 8 << i;
      st = 24'h40 + 24'(dep - 2);
      `HM.setBurst(1'b0, 8'(i));
      ahbRead(OFS_STATUS);
      `CHECK("wrap select", {i[1:0], 1'b1}, d[3:1])
      `HM.readFrame(1'b0, 1'b1, i[0] ? OP_QUAD_IO_SHORT : OP_QUAD_IO_READ, 1'b1, st, 8'h00,
                    i[0] ? int'(DUMMY_SHORT) : int'(DUMMY_DC0), 3);
      chkBytes(st, 3, dep);
      `HM.endFrame();
    end
    ahbWrite(OFS_CTRL, 32'h3);
    `HM.setBurst(1'b1, 8'h00);
    ahbRead(OFS_STATUS);
    `CHECK("wrap set in quad mode", 3'b001, d[3:1])
    `HM.setBurst(1'b1, 8'h10);
    ahbRead(OFS_STATUS);
    `CHECK("wrap off", 1'b0, d[1])
    `HM.readFrame(1'b1, 1'b1, OP_QUAD_IO_READ, 1'b1, 24'h3E, 8'h00, 6, 3);
    chkBytes(24'h3E, 3, 0);
    `HM.endFrame();
    ahbWrite(OFS_CTRL, 32'h1);
  endtask : scnBurst
  task automatic scnEnhance();
    `HM.readFrame(1'b0, 1'b1, OP_QUAD_IO_READ, 1'b1, 24'h50, 8'hA5, 6, 1);
    `HM.endFrame();
    chkEnh(1'b1);
    `HM.readFrame(1'b0, 1'b0, 8'h00, 1'b1, 24'h60, 8'hAA, 6, 2);
    chkBytes(24'h60, 2, 0);
    `HM.endFrame();
    chkEnh(1'b0);
    `HM.readFrame(1'b0, 1'b1, OP_QUAD_IO_READ, 1'b1, 24'h70, 8'h5A, 6, 1);
    `HM.endFrame();
    `HM.exitFrame(1'b0);
    chkEnh(1'b0);
    `HM.endFrame();
    `HM.readFrame(1'b0, 1'b1, OP_QUAD_IO_READ, 1'b1, 24'h80, 8'h00, 6, 1);
    chkBytes(24'h80, 1, 0);
    `HM.endFrame();
    ahbWrite(OFS_CTRL, 32'h3);
    `HM.readFrame(1'b1, 1'b1, OP_QUAD_IO_READ, 1'b1, 24'h90, 8'hF0, 6, 1);
    `HM.endFrame();
    chkEnh(1'b1);
    `HM.exitFrame(1'b1);
    chkEnh(1'b0);
    `HM.endFrame();
    chkEnh(1'b0);
  endtask : scnEnhance
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  // Main sequence
  initial begin
    mclk = 1'b0;
    reset_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    scnReset();
    scnRefused();
    scnQuadOut();
    scnDummy();
    scnBurst();
    scnEnhance();
    give_verdict();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #4000000;
    fails++;
    give_verdict();
  end
endmodule : quad_read_burst_xip_engine_tb
`default_nettype wire
